/* File: bench/complementary_waveform_gen_tb_top.sv */
// Self-checking bench of the complementary waveform generator
`default_nettype none
module complementary_waveform_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, ce, avs_read, avs_write, wave_in, trip, fault;
  logic [3:0] avs_address, avs_byteenable;
  logic [2:0] flt_hi;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, da, db, dc, dd, irq;
  logic [31:0] q[$];
  logic [7:0] v;
  int n_fail, num_checks, cyc, t0;
  cwg_top uut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wave_in(wave_in), .fault_in({flt_hi, fault}), .drive_out_a(da),
    .drive_out_b(db), .drive_out_c(dc), .drive_out_d(dd), .irq(irq));
  cwg_bridge_model u_sw (.clk(clk), .hi_a(da), .hi_c(dc), .trip(trip),
    .fault(fault));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Bus master: hold the request until waitrequest is seen low
  // ----------------------------------------------------------------
  task automatic bus(input logic rd, input logic [3:0] ad,
                     input logic [31:0] d, input logic [3:0] be);
    avs_address <= ad;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= rd;
    avs_write <= !rd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    bus(1'b0, ad, d, 4'h3);
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    q.push_back(e);
    bus(1'b1, ad, 32'h0, 4'hf);
  endtask : rd
  task automatic outs(input logic [3:0] e);
    repeat (8) @(posedge clk);
    check({28'h0, da, db, dc, dd}, {28'h0, e});
  endtask : outs
  task automatic wait_irq(input logic e);
    for (t0 = 0; t0 < 20 && irq !== e; t0++) @(posedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask : wait_irq
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      check(avs_readdata, q.pop_front());
    end
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {sys_rst, ce, avs_read, avs_write, wave_in, trip, flt_hi} = 9'h180;
    {avs_address, avs_byteenable, avs_writedata} = 40'h0;
    v = 8'($urandom(7));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(cwg_pkg::ADDR_INVERT, 32'h0);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0);
    wave_in <= 1'b1;
    repeat (4) begin
      v = 8'($urandom);
      wr(cwg_pkg::ADDR_INVERT, {24'h0, v});
      rd(cwg_pkg::ADDR_INVERT, {24'h0, v & 8'h0f} | 32'h20);
    end
    wr(cwg_pkg::ADDR_INVERT, 32'h0a);
    wr(cwg_pkg::ADDR_CTRL0, 32'h84);
    outs(4'hf);
    wr(cwg_pkg::ADDR_INVERT, 32'h0);
    repeat (40) @(posedge clk) wave_in <= 1'($urandom);
    wr(cwg_pkg::ADDR_DBAND, 32'h0305);
    wave_in <= 1'b0;
    repeat (12) @(posedge clk);
    wave_in <= 1'b1;
    for (t0 = 0; da !== 1'b1 && cyc < 4000; ) begin
      @(posedge clk);
      if (db === 1'b0) t0++;
    end
    check(32'(t0 >= 5 && t0 <= 7), 32'h1);
    wr(cwg_pkg::ADDR_DBAND, 32'h0);
    wr(cwg_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(cwg_pkg::ADDR_SHUT, 32'h0a01);
    trip <= 1'b1;
    wait_irq(1'b1);
    outs(4'h0);
    trip <= 1'b0;
    wr(cwg_pkg::ADDR_IRQ_MASK, 32'h0);
    wait_irq(1'b0);
    wr(cwg_pkg::ADDR_IRQ_MASK, 32'h1);
    wait_irq(1'b1);
    wr(cwg_pkg::ADDR_SHUT, 32'h0);
    wr(cwg_pkg::ADDR_IRQ_STAT, 32'h1);
    wait_irq(1'b0);
    outs(4'ha);
    // Auto-restart: A/C hold, B/D forced high, release at next input rise
    wr(cwg_pkg::ADDR_SHUT, 32'h0c11);
    trip <= 1'b1;
    outs(4'hf);
    trip <= 1'b0;
    wave_in <= 1'b0;
    outs(4'hf);
    wave_in <= 1'b1;
    outs(4'ha);
    wr(cwg_pkg::ADDR_SHUT, 32'h0);
    wr(cwg_pkg::ADDR_CTRL0, 32'h80);
    wr(cwg_pkg::ADDR_STEER, 32'h50);
    outs(4'ha);
    wave_in <= 1'b0;
    wr(cwg_pkg::ADDR_CTRL0, 32'h81);
    wr(cwg_pkg::ADDR_STEER, 32'ha0);
    outs(4'ha);
    wave_in <= 1'b1;
    outs(4'h5);
    wr(cwg_pkg::ADDR_CTRL0, 32'h82);
    outs(4'h9);
    wr(cwg_pkg::ADDR_CTRL0, 32'h83);
    outs(4'h6);
    wr(cwg_pkg::ADDR_CTRL0, 32'h85);
    repeat (30) @(posedge clk) wave_in <= 1'($urandom);
    // Push-pull: one input rise hands the drive to the other rail pair
    wave_in <= 1'b0;
    repeat (8) @(posedge clk);
    v[0] = db;
    wave_in <= 1'b1;
    repeat (8) @(posedge clk);
    wave_in <= 1'b0;
    outs({1'b0, !v[0], 1'b0, !v[0]});
    summarize();
  end
endmodule : complementary_waveform_gen_tb_top
`default_nettype wire

/* File: bench/cwg_bridge_model.sv */
// Behavioural bridge switch stage that reports an overcurrent trip
`default_nettype none
module cwg_bridge_model (
  input wire logic clk,
  input wire logic hi_a,
  input wire logic hi_c,
  input wire logic trip,
  output logic fault
);
  timeunit 1ns;
  timeprecision 1ns;
  // Overcurrent needs a conducting high side, so a shutdown that drives A and C low removes it
  always_ff @(posedge clk) fault <= trip && (hi_a || hi_c);
endmodule : cwg_bridge_model
`default_nettype wire

/* File: bench/cwg_top_props.sv */
// Checker of bus handshake, register and half-bridge output relations
`default_nettype none
module cwg_top_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic wave_in,
  input wire logic drive_out_a,
  input wire logic drive_out_b,
  input wire logic drive_out_c,
  input wire logic drive_out_d
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Shadow of the configuration seen on the bus
  // ----------------------------------------------------------------
  logic [2:0] mode_r;
  logic en_r, sd_r, dz_r;
  logic [3:0] inv_r, cnt_r;
  wire wr_ack = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  // Outputs lag the bus by a few cycles, so judge only a settled setup
  wire half_db = cnt_r == 4'hf && en_r && !sd_r &&
    mode_r == cwg_pkg::MODE_HALF;
  // Exact input copy only without dead-band; the rest holds with it too
  wire half = half_db && dz_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {mode_r, en_r, sd_r, dz_r, inv_r, cnt_r} <= 14'h100;
    end else begin
      cnt_r <= wr_ack ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hf};
      if (wr_ack && avs_address == cwg_pkg::ADDR_CTRL0) begin
        {en_r, mode_r} <= {wd[7], wd[2:0]};
      end
      if (wr_ack && avs_address == cwg_pkg::ADDR_INVERT) inv_r <= wd[3:0];
      if (wr_ack && avs_address == cwg_pkg::ADDR_SHUT) begin
        sd_r <= |avs_writedata[12:0];
      end
      if (wr_ack && avs_address == cwg_pkg::ADDR_DBAND) begin
        dz_r <= avs_writedata[13:0] == 14'h0;
      end
    end
  end
  a_ack_one_wait: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("ack late");
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack held too long");
  a_ack_has_cause: assert property (!avs_waitrequest |->
    $past(avs_read || avs_write)) else $error("ack without request");
  a_inv_unused_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address == cwg_pkg::ADDR_INVERT |-> {avs_readdata[31:6],
    avs_readdata[4]} == 27'h0) else $error("unused bits not zero");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address > cwg_pkg::ADDR_IRQ_MASK |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($past(sys_rst) |-> avs_waitrequest &&
    !(drive_out_a | drive_out_b | drive_out_c | drive_out_d))
    else $error("outputs active after reset");
  a_half_true_copy: assert property (half |->
    (drive_out_a ^ inv_r[0]) == $past(wave_in, 4)) else $error("A not input");
  a_half_no_overlap: assert property (half_db |->
    !((drive_out_a ^ inv_r[0]) && (drive_out_b ^ inv_r[1])))
    else $error("A and B overlap");
  a_half_cd_follow: assert property (half_db |->
    (drive_out_c ^ inv_r[2]) == (drive_out_a ^ inv_r[0]) &&
    (drive_out_d ^ inv_r[3]) == (drive_out_b ^ inv_r[1]))
    else $error("C or D not following");
endmodule : cwg_top_props
bind cwg_top cwg_top_props u_props (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .wave_in(wave_in), .drive_out_a(drive_out_a), .drive_out_b(drive_out_b),
  .drive_out_c(drive_out_c), .drive_out_d(drive_out_d));
`default_nettype wire

/* File: hw/cwg_deadband.sv */
// Clocked dead-band delay of rising and falling edges
`default_nettype none
module cwg_deadband (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_lvl,
  input wire logic [cwg_pkg::DB_W-1:0] rise_cnt,
  input wire logic [cwg_pkg::DB_W-1:0] fall_cnt,
  output logic out_lvl
);
  // Rising edges are delayed by rise_cnt, falling ones by fall_cnt.
  // A new edge during a count restarts it, so short pulses vanish.
  logic [cwg_pkg::DB_W-1:0] cnt_r;
  logic prev_r;
  cwg_pkg::cwg_db_state_t st_r;
  wire edge_seen = in_lvl != prev_r;
  wire [cwg_pkg::DB_W-1:0] load_val = in_lvl ? rise_cnt : fall_cnt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      prev_r <= 1'b0;
      out_lvl <= 1'b0;
      st_r <= cwg_pkg::DB_IDLE;
    end else if (ce) begin
      prev_r <= in_lvl;
      if (edge_seen) begin
        if (load_val == '0) begin
          out_lvl <= in_lvl;
          st_r <= cwg_pkg::DB_IDLE;
        end else begin
          cnt_r <= load_val - 1'b1;
          st_r <= in_lvl ? cwg_pkg::DB_RISE : cwg_pkg::DB_FALL;
        end
      end else begin
        unique case (st_r)
          cwg_pkg::DB_IDLE: out_lvl <= in_lvl;
          cwg_pkg::DB_RISE, cwg_pkg::DB_FALL: begin
            if (cnt_r == '0) begin
              out_lvl <= in_lvl;
              st_r <= cwg_pkg::DB_IDLE;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          default: st_r <= cwg_pkg::DB_IDLE;
        endcase
      end
    end
  end
endmodule : cwg_deadband
`default_nettype wire

/* File: hw/cwg_pkg.sv */
// Package: register map, field layout, modes and states of the waveform generator
`default_nettype none
package cwg_pkg;
  // Register word addresses; the four address bits reach every register
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_INVERT = 4'h1;
  localparam logic [3:0] ADDR_DBAND = 4'h2;
  localparam logic [3:0] ADDR_SHUT = 4'h3;
  localparam logic [3:0] ADDR_STEER = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam int ADDR_LSB = 2;

  // Control register 0 fields
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int CTRL0_LD = 6;
  localparam int CTRL0_EN = 7;
  // Polarity register fields
  localparam int INV_W = 4;
  localparam int INV_IN_BIT = 5;
  localparam logic [3:0] INV_RST = 4'h0;
  localparam logic [7:0] INV_WMASK = 8'h0f;
  // Dead-band register fields
  localparam int DB_W = 6;
  localparam int DB_RISE_LSB = 0;
  localparam int DB_FALL_LSB = 8;
  // Shutdown register fields
  localparam int SHUT_SRC_LSB = 0;
  localparam int SHUT_SRC_W = 4;
  localparam int SHUT_REN = 4;
  localparam int SHUT_ABCD_LSB = 8;
  localparam int SHUT_OVR_W = 2;
  localparam int SHUT_SW = 12;
  localparam int SHUT_ACT = 15;
  // Steering register fields
  localparam int STR_EN_LSB = 0;
  localparam int STR_DAT_LSB = 4;
  // Interrupt bits
  localparam int IRQ_W = 2;
  localparam int IRQ_SHUT = 0;
  localparam int IRQ_RISE = 1;

  // Shutdown override codes
  localparam logic [1:0] OVR_HOLD = 2'h0;
  localparam logic [1:0] OVR_INACT = 2'h1;
  localparam logic [1:0] OVR_LOW = 2'h2;
  localparam logic [1:0] OVR_HIGH = 2'h3;

  typedef enum logic [2:0] {
    MODE_STEER_ASYNC = 3'h0,
    MODE_STEER_SYNC = 3'h1,
    MODE_FULL_FWD = 3'h2,
    MODE_FULL_REV = 3'h3,
    MODE_HALF = 3'h4,
    MODE_PUSH_PULL = 3'h5
  } cwg_mode_t;

  typedef enum logic [1:0] {
    DB_IDLE = 2'b00,
    DB_RISE = 2'b01,
    DB_FALL = 2'b10
  } cwg_db_state_t;
endpackage : cwg_pkg
`default_nettype wire

/* File: hw/cwg_sync.sv */
// Two-flop synchroniser for asynchronous level inputs
`default_nettype none
module cwg_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : cwg_sync
`default_nettype wire

/* File: hw/cwg_top.sv */
// Complementary waveform generator with Avalon-MM registers
//
// Summary of operation
// R01: Six modes: half, push-pull, full fwd/rev, async and sync steering.
// R02: Half-bridge drives output A true and output B inverted copy of input.
// R03: Half-bridge inserts dead-band so A and B never overlap at edges.
// R04: In half-bridge, C and D follow A and B with own polarity.
// R05: Bits 0 to 3 invert outputs A to D individually when set.
// R06: Polarity bits reset to zero, normal polarity.
// R07: Bit 5 of polarity register reads the current input level.
// R08: All modes auto-shutdown with source select, auto-restart and override.
// R09: Separate 6-bit clocked rise and fall dead-band counters, each enabled.
// R10: Steering changes apply at next input rise or immediately.
// R11: Polarity register bits 7, 6, 4 ignore writes, read zero.
`default_nettype none
module cwg_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wave_in,
  input wire logic [cwg_pkg::SHUT_SRC_W-1:0] fault_in,
  output logic drive_out_a,
  output logic drive_out_b,
  output logic drive_out_c,
  output logic drive_out_d,
  output logic irq
);
  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic in_s;
  logic [cwg_pkg::SHUT_SRC_W-1:0] fault_s;
  cwg_sync #(.W(1 + cwg_pkg::SHUT_SRC_W)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in({wave_in, fault_in}),
    .sync_out({in_s, fault_s})
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl0_r;
  logic [cwg_pkg::INV_W-1:0] invert_r;
  logic [15:0] dband_r;
  logic [15:0] shut_r;
  logic [7:0] steer_r;
  logic [7:0] steer_act_r;
  logic [cwg_pkg::IRQ_W-1:0] irq_stat_r;
  logic [cwg_pkg::IRQ_W-1:0] irq_mask_r;
  logic shut_act_r;
  logic in_prev_r;
  logic ack_r;
  logic push_tgl_r;

  // Bus decode: one cycle wait, then answer on the next edge
  wire acc = (avs_read | avs_write) & ~ack_r;
  // Word addressing: a byte address in four bits could not reach 0x10 up
  wire [3:0] widx = avs_address;
  wire wr = avs_write & ack_r;
  wire wr_ctrl0 = wr & avs_byteenable[0] & (widx == cwg_pkg::ADDR_CTRL0);
  wire wr_inv = wr & avs_byteenable[0] & (widx == cwg_pkg::ADDR_INVERT);
  wire wr_db = wr & (widx == cwg_pkg::ADDR_DBAND);
  wire wr_shut = wr & (widx == cwg_pkg::ADDR_SHUT);
  wire wr_steer = wr & avs_byteenable[0] & (widx == cwg_pkg::ADDR_STEER);
  wire wr_stat = wr & avs_byteenable[0] & (widx == cwg_pkg::ADDR_IRQ_STAT);
  wire wr_mask = wr & avs_byteenable[0] & (widx == cwg_pkg::ADDR_IRQ_MASK);

  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge

  wire cwg_en = ctrl0_r[cwg_pkg::CTRL0_EN];
  wire [cwg_pkg::MODE_W-1:0] mode_raw =
    ctrl0_r[cwg_pkg::MODE_LSB +: cwg_pkg::MODE_W];
  wire in_rise = in_s & ~in_prev_r;

  // ----------------------------------------------------------------
  // Auto-shutdown
  // ----------------------------------------------------------------
  wire [cwg_pkg::SHUT_SRC_W-1:0] shut_src =
    shut_r[cwg_pkg::SHUT_SRC_LSB +: cwg_pkg::SHUT_SRC_W];
  wire fault_now = |(fault_s & shut_src) | shut_r[cwg_pkg::SHUT_SW];
  wire restart_ok = shut_r[cwg_pkg::SHUT_REN] & ~fault_now & in_rise;
  wire sw_clr_shut = wr_shut & avs_byteenable[1]
                   & ~avs_writedata[cwg_pkg::SHUT_ACT];
  wire shut_set = fault_now & ~shut_act_r;
  // Fault wins over a restart or a software clear in the same cycle
  wire shut_nxt = fault_now | (shut_act_r & ~restart_ok & ~sw_clr_shut);

  // ----------------------------------------------------------------
  // Steering: sync mode loads at next input rise, async loads at once
  // ----------------------------------------------------------------
  wire steer_sync = (mode_raw == cwg_pkg::MODE_STEER_SYNC);
  wire steer_load = ~steer_sync | in_rise;

  // ----------------------------------------------------------------
  // Dead-band
  // ----------------------------------------------------------------
  wire [cwg_pkg::DB_W-1:0] db_rise =
    dband_r[cwg_pkg::DB_RISE_LSB +: cwg_pkg::DB_W];
  wire [cwg_pkg::DB_W-1:0] db_fall =
    dband_r[cwg_pkg::DB_FALL_LSB +: cwg_pkg::DB_W];
  wire src_a = in_s & cwg_en;
  wire src_b = ~in_s & cwg_en;
  logic del_a;
  logic del_b;
  // Each rail delays only its own rising edge, so both rails are low
  // for the programmed time around every input transition
  cwg_deadband u_db_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_lvl(src_a),
    .rise_cnt(db_rise),
    .fall_cnt('0),
    .out_lvl(del_a)
  ); // R03 R09
  cwg_deadband u_db_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_lvl(src_b),
    .rise_cnt(db_fall),
    .fall_cnt('0),
    .out_lvl(del_b)
  ); // R03 R09

  // ----------------------------------------------------------------
  // Mode output mapping (before polarity)
  // ----------------------------------------------------------------
  logic [3:0] raw;
  wire [3:0] str_en = steer_act_r[cwg_pkg::STR_EN_LSB +: 4];
  wire [3:0] str_dat = steer_act_r[cwg_pkg::STR_DAT_LSB +: 4];
  wire in_g = in_s & cwg_en;
  always_comb begin
    raw = 4'h0;
    unique case (mode_raw)
      cwg_pkg::MODE_HALF: raw = {del_b, del_a, del_b, del_a}; // R02 R04
      cwg_pkg::MODE_PUSH_PULL:
        raw = {del_b & ~push_tgl_r, del_a & push_tgl_r,
               del_b & ~push_tgl_r, del_a & push_tgl_r};
      // Forward: A on, D modulated; reverse: C on, B modulated
      cwg_pkg::MODE_FULL_FWD: raw = {in_g, 1'b0, 1'b0, cwg_en};
      cwg_pkg::MODE_FULL_REV: raw = {1'b0, cwg_en, in_g, 1'b0};
      cwg_pkg::MODE_STEER_ASYNC, cwg_pkg::MODE_STEER_SYNC: begin
        for (int i = 0; i < 4; i++) begin
          raw[i] = str_en[i] ? in_g : str_dat[i];
        end
      end
      default: raw = 4'h0;
    endcase
  end // R01

  // Override during shutdown, otherwise polarity per output
  wire [1:0] ovr_ac = shut_r[cwg_pkg::SHUT_ABCD_LSB +: cwg_pkg::SHUT_OVR_W];
  wire [1:0] ovr_bd = shut_r[cwg_pkg::SHUT_ABCD_LSB + cwg_pkg::SHUT_OVR_W
                             +: cwg_pkg::SHUT_OVR_W];
  logic [3:0] pin_nxt;
  logic [3:0] pin_r;

  function automatic logic ovr_pin(input logic [1:0] code, input logic cur,
                                   input logic pol);
    unique case (code)
      cwg_pkg::OVR_HOLD: ovr_pin = cur;
      cwg_pkg::OVR_INACT: ovr_pin = pol;
      cwg_pkg::OVR_LOW: ovr_pin = 1'b0;
      cwg_pkg::OVR_HIGH: ovr_pin = 1'b1;
    endcase
  endfunction : ovr_pin

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (shut_act_r) begin
        pin_nxt[i] = ovr_pin(i[0] ? ovr_bd : ovr_ac, pin_r[i],
                             invert_r[i]); // R08
      end else begin
        pin_nxt[i] = raw[i] ^ invert_r[i]; // R05
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0;
    unique case (widx)
      cwg_pkg::ADDR_CTRL0: rd_nxt[7:0] = ctrl0_r;
      cwg_pkg::ADDR_INVERT: begin
        rd_nxt[cwg_pkg::INV_W-1:0] = invert_r;
        rd_nxt[cwg_pkg::INV_IN_BIT] = in_s; // R07 R11
      end
      cwg_pkg::ADDR_DBAND: rd_nxt[15:0] = dband_r;
      cwg_pkg::ADDR_SHUT: begin
        rd_nxt[15:0] = shut_r;
        rd_nxt[cwg_pkg::SHUT_ACT] = shut_act_r;
      end
      cwg_pkg::ADDR_STEER: rd_nxt[7:0] = steer_r;
      cwg_pkg::ADDR_IRQ_STAT: rd_nxt[cwg_pkg::IRQ_W-1:0] = irq_stat_r;
      cwg_pkg::ADDR_IRQ_MASK: rd_nxt[cwg_pkg::IRQ_W-1:0] = irq_mask_r;
      default: rd_nxt = 32'h0;
    endcase
  end

  wire [cwg_pkg::IRQ_W-1:0] ev = {in_rise, shut_set};
  wire [cwg_pkg::IRQ_W-1:0] stat_clr =
    wr_stat ? avs_writedata[cwg_pkg::IRQ_W-1:0] : '0;
  wire [cwg_pkg::IRQ_W-1:0] stat_nxt = ev | (irq_stat_r & ~stat_clr);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl0_r <= 8'h00;
      invert_r <= cwg_pkg::INV_RST; // R06
      dband_r <= 16'h0000;
      shut_r <= 16'h0000;
      steer_r <= 8'h00;
      steer_act_r <= 8'h00;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      shut_act_r <= 1'b0;
      in_prev_r <= 1'b0;
      ack_r <= 1'b0;
      push_tgl_r <= 1'b0;
      pin_r <= 4'h0;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
    end else if (ce) begin
      ack_r <= acc;
      avs_waitrequest <= ~acc;
      if (acc) avs_readdata <= rd_nxt;
      if (wr_ctrl0) ctrl0_r <= avs_writedata[7:0];
      if (wr_inv) invert_r <= avs_writedata[cwg_pkg::INV_W-1:0]; // R05 R11
      if (wr_db) dband_r <= be_merge(dband_r, avs_writedata, avs_byteenable);
      if (wr_shut) shut_r <= be_merge(shut_r, avs_writedata, avs_byteenable);
      if (wr_steer) steer_r <= avs_writedata[7:0];
      if (wr_mask) irq_mask_r <= avs_writedata[cwg_pkg::IRQ_W-1:0];
      if (steer_load) steer_act_r <= steer_r; // R10
      irq_stat_r <= stat_nxt;
      irq <= |(stat_nxt & irq_mask_r);
      shut_act_r <= shut_nxt; // R08
      in_prev_r <= in_s;
      if (in_rise) push_tgl_r <= ~push_tgl_r;
      pin_r <= pin_nxt;
    end
  end

  assign drive_out_a = pin_r[0];
  assign drive_out_b = pin_r[1];
  assign drive_out_c = pin_r[2];
  assign drive_out_d = pin_r[3];
endmodule : cwg_top
`default_nettype wire
